// file: fetch_consts.vh
`ifndef FETCH_CONSTS_VH
`define FETCH_CONSTS_VH
// =====================================
// Phase codes
`define PH_ONE 2'h0
`define PH_TWO 2'h1
`define PH_THREE 2'h2
`define PH_FOUR 2'h3
// =====================================
// Program space
`define PC_W 13
`define IMPL_AW 12
`define WORD_W 14
`define RESET_VEC 13'h0000
`define INT_VEC 13'h0004
`define VEC_LAST 12'h004
`define PAGE0_LAST 12'h7ff
`define PAGE1_FIRST 12'h800
`define PAGE1_LAST 12'hfbf
`define CAL_FIRST 12'hfc0
`define NOP_WORD 14'h0000
`endif

// file: phase_gen.v
`default_nettype none
`include "fetch_consts.vh"
// =====================================
// Quarter-rate phase sequencer
module phase_gen (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire run_i,
    output reg [1:0] phase_o
);
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_o <= `PH_ONE;
        end else if (!run_i) begin
            phase_o <= `PH_ONE;
        end else begin
            phase_o <= phase_o + 2'h1;
        end
    end
endmodule // phase_gen
`default_nettype wire

// file: instruction_fetch_pipeline.v
`default_nettype none
`include "fetch_consts.vh"
// Overview of operation
// - The input clock is divided by four into four non-overlapping phases in fixed order.
// - The program counter advances by one in phase one, starting the next fetch.
// - The program word is captured into the holding register in phase four.
// - Fetch of one word overlaps the execution of the previous one.
// - The latched word is decoded and executed over phases two to four.
// - Operand read strobes in phase two, result write strobes in phase four.
// - A flow change takes two cycles, flushing the prefetched word.
// - Non-branching instructions complete at one per instruction cycle.
// - The program counter is 13 bits wide over an 8K-word space.
// - Only the low 4K words exist and higher addresses wrap onto them.
// - Reset starts at word zero and an interrupt loads word four.
// - The top 64 words hold calibration data and are never executed.
// - Code lives in page zero after the vectors and page one below calibration.
// - The core is held in reset while the external reset is low.
// - Oscillator input pin is a pulled-up interrupt input or the crystal input.
// - Oscillator output pin is a general output or the clock output.
module instruction_fetch_pipeline (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire external_reset_n_i,
    input wire crystal_osc_mode_i,
    input wire oscillator_in_pin_i,
    input wire gp_out_i,
    input wire irq_req_i,
    input wire branch_i,
    input wire [12:0] branch_target_i,
    input wire [13:0] prog_data_i,
    output reg [11:0] prog_addr_o,
    output reg prog_rd_o,
    output reg [13:0] instruction_latch_o,
    output reg exec_valid_o,
    output reg [12:0] pc_o,
    output reg phase_one_o,
    output reg phase_two_o,
    output reg phase_three_o,
    output reg phase_four_o,
    output reg operand_rd_o,
    output reg result_wr_o,
    output reg oscillator_out_pin_o,
    output reg osc_pin_irq_o,
    output reg osc_pin_pullup_o,
    output reg cal_fetch_o,
    output reg [1:0] code_region_o
);
// =====================================
// Pin synchronisers
    reg rst_s1_q, rst_s2_q, xtal_s1_q, xtal_s2_q, pin_s1_q, pin_s2_q, pin_last_q;
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
            xtal_s1_q <= 1'b0;
            xtal_s2_q <= 1'b0;
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            rst_s1_q <= external_reset_n_i;
            rst_s2_q <= rst_s1_q;
            xtal_s1_q <= crystal_osc_mode_i;
            xtal_s2_q <= xtal_s1_q;
            pin_s1_q <= oscillator_in_pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end
    wire run = rst_s2_q;
// =====================================
// Phases
    wire [1:0] phase;
    phase_gen u_phase (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .run_i(run),
        .phase_o(phase)
    );
    wire ph1 = run && (phase == `PH_ONE);
    wire ph2 = run && (phase == `PH_TWO);
    wire ph4 = run && (phase == `PH_FOUR);
// =====================================
// Address map helpers
    function [11:0] wrap_addr;
        input [12:0] a;
        begin
            wrap_addr = a[11:0];
        end
    endfunction
    function [1:0] region_of;
        input [11:0] a;
        begin
            if (a <= `VEC_LAST) region_of = 2'h0;
            else if (a <= `PAGE0_LAST) region_of = 2'h1;
            else if (a <= `PAGE1_LAST) region_of = 2'h2;
            else region_of = 2'h3;
        end
    endfunction
// =====================================
// Fetch and execute pipeline
    reg [12:0] pc_q;
    reg [13:0] fetch_q;
    reg fetch_ok_q;
    reg first_q;
    reg [12:0] next_pc_d;
    wire cal_now = (region_of(wrap_addr(pc_q)) == 2'h3);
    always @* begin
        if (irq_req_i) next_pc_d = `INT_VEC;
        else if (branch_i) next_pc_d = branch_target_i;
        else next_pc_d = pc_q + 13'h0001;
    end
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pc_q <= `RESET_VEC;
            fetch_q <= `NOP_WORD;
            fetch_ok_q <= 1'b0;
            first_q <= 1'b1;
            instruction_latch_o <= `NOP_WORD;
            exec_valid_o <= 1'b0;
        end else if (!run) begin
            pc_q <= `RESET_VEC;
            fetch_ok_q <= 1'b0;
            first_q <= 1'b1;
            exec_valid_o <= 1'b0;
        end else begin
            if (ph1) begin
                // Prefetched word moves to execute stage
                instruction_latch_o <= fetch_q;
                // Word prefetched behind a flow change is dropped, target runs next
                exec_valid_o <= fetch_ok_q && !irq_req_i && !branch_i;
                // First cycle after reset fetches word zero itself
                if (first_q) begin
                    first_q <= 1'b0;
                end else begin
                    pc_q <= next_pc_d;
                end
            end
            if (ph4) begin
                fetch_q <= prog_data_i;
                // Calibration words never become instructions
                fetch_ok_q <= !cal_now;
            end
        end
    end
// =====================================
// Output registers
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prog_addr_o <= 12'h000;
            prog_rd_o <= 1'b0;
            pc_o <= `RESET_VEC;
            phase_one_o <= 1'b0;
            phase_two_o <= 1'b0;
            phase_three_o <= 1'b0;
            phase_four_o <= 1'b0;
            operand_rd_o <= 1'b0;
            result_wr_o <= 1'b0;
            oscillator_out_pin_o <= 1'b0;
            osc_pin_irq_o <= 1'b0;
            osc_pin_pullup_o <= 1'b0;
            pin_last_q <= 1'b1;
            cal_fetch_o <= 1'b0;
            code_region_o <= 2'h0;
        end else begin
            prog_addr_o <= wrap_addr(pc_q);
            prog_rd_o <= run;
            pc_o <= pc_q;
            // Registered copies lag the phase count by one clock
            phase_one_o <= ph1;
            phase_two_o <= ph2;
            phase_three_o <= run && (phase == `PH_THREE);
            phase_four_o <= ph4;
            operand_rd_o <= ph2 && exec_valid_o;
            result_wr_o <= ph4 && exec_valid_o;
            // Clock out is high for phases one and two
            oscillator_out_pin_o <= xtal_s2_q ? (ph1 || ph2) : gp_out_i;
            osc_pin_pullup_o <= !xtal_s2_q;
            pin_last_q <= pin_s2_q;
            // Falling edge, as from a button to ground
            osc_pin_irq_o <= !xtal_s2_q && pin_last_q && !pin_s2_q;
            cal_fetch_o <= cal_now;
            code_region_o <= region_of(wrap_addr(pc_q));
        end
    end
endmodule // instruction_fetch_pipeline
`default_nettype wire

// file: ifp_props.sv
`default_nettype none
module ifp_props (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic external_reset_n_i,
    input wire logic oscillator_in_pin_i,
    input wire logic [12:0] pc_o,
    input wire logic exec_valid_o,
    input wire logic phase_one_o,
    input wire logic phase_two_o,
    input wire logic phase_three_o,
    input wire logic phase_four_o,
    input wire logic operand_rd_o,
    input wire logic result_wr_o,
    input wire logic osc_pin_irq_o,
    input wire logic osc_pin_pullup_o,
    input wire logic cal_fetch_o,
    input wire logic [1:0] code_region_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    // ==========================================
    // Phases and strobes
    // Pin high four samples back, so the synced run flag cannot drop mid-check
    sequence s_run; external_reset_n_i [*4]; endsequence
    property p_one_hot; $onehot0({phase_one_o, phase_two_o, phase_three_o, phase_four_o}); endproperty
    a_one_hot: assert property (p_one_hot) else $error("phases overlap");
    property p_one_two; s_run ##0 phase_one_o |=> phase_two_o; endproperty
    a_one_two: assert property (p_one_two) else $error("phase two missing");
    property p_three_four; s_run ##0 phase_three_o |=> phase_four_o; endproperty
    a_three_four: assert property (p_three_four) else $error("phase four missing");
    property p_rd; operand_rd_o == (phase_two_o && exec_valid_o); endproperty
    a_rd: assert property (p_rd) else $error("operand read strobe");
    property p_wr; result_wr_o == (phase_four_o && exec_valid_o); endproperty
    a_wr: assert property (p_wr) else $error("result write strobe");
    // ==========================================
    // Reset, map and pins
    // Five samples: two sync stages, the clearing edge and the output register
    property p_hold; !external_reset_n_i [*5] |-> pc_o == 13'h0000 && !exec_valid_o; endproperty
    a_hold: assert property (p_hold) else $error("pin reset not held");
    property p_cal; cal_fetch_o == (code_region_o == 2'h3); endproperty
    a_cal: assert property (p_cal) else $error("calibration region");
    property p_irq; osc_pin_irq_o |-> osc_pin_pullup_o; endproperty
    a_irq: assert property (p_irq) else $error("pin irq in crystal mode");
    property p_irq_edge;
        osc_pin_irq_o |-> !$past(oscillator_in_pin_i, 3) && $past(oscillator_in_pin_i, 4);
    endproperty
    a_irq_edge: assert property (p_irq_edge) else $error("pin irq without falling edge");
    c_wr: cover property (result_wr_o);
    c_cal: cover property (cal_fetch_o);
    c_irq: cover property (osc_pin_irq_o);
endmodule // ifp_props
`default_nettype wire

// file: prog_mem_model.sv
`default_nettype none
module prog_mem_model (
    input wire logic [11:0] addr_i,
    input wire logic rd_i,
    output logic [13:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Word carries its address; idle shows a pattern, not the last word
    assign data_o = rd_i ? {~addr_i[1:0], addr_i} : 14'h2aaa;
endmodule // prog_mem_model
`default_nettype wire

// file: testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0, arst_n_i = 1'b0, ext_n = 1'b1, xtal = 1'b0, xq = 1'b0;
    logic osc_in = 1'b1, gp = 1'b0, irq = 1'b0, br = 1'b0, first = 1'b1;
    logic rd, valid, p2, p3, oout, opu, cal;
    logic [12:0] tgt = 13'h0000, pc_m = 13'h0000, nx, pc;
    logic [13:0] word, latch;
    logic [11:0] addr, a;
    logic [1:0] region, er;
    logic [31:0] r;
    integer failures = 0, samples_checked = 0, seed = 32'h9dae;
    always #2 core_clk_i = ~core_clk_i;
    instruction_fetch_pipeline uut (.core_clk_i, .arst_n_i, .external_reset_n_i(ext_n),
        .crystal_osc_mode_i(xtal), .oscillator_in_pin_i(osc_in), .gp_out_i(gp), .irq_req_i(irq),
        .branch_i(br), .branch_target_i(tgt), .prog_data_i(word), .prog_addr_o(addr),
        .prog_rd_o(rd), .instruction_latch_o(latch), .exec_valid_o(valid), .pc_o(pc),
        .phase_one_o(), .phase_two_o(p2), .phase_three_o(p3), .phase_four_o(),
        .operand_rd_o(), .result_wr_o(), .oscillator_out_pin_o(oout), .osc_pin_irq_o(),
        .osc_pin_pullup_o(opu), .cal_fetch_o(cal), .code_region_o(region));
    prog_mem_model mem (.addr_i(addr), .rd_i(rd), .data_o(word));
    task chk(input string n, input logic [13:0] e, input logic [13:0] s);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task test_done;
        if (failures == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ==========================================
    // Stimulus, held for a whole instruction cycle
    always @(posedge core_clk_i) if (p3 && ext_n) begin
        r = $random(seed);
        br <= r[1:0] == 2'h0;
        irq <= r[5:2] == 4'h0;
        // A quarter of targets land in calibration space, bit 12 tests wrap
        tgt <= (r[6] & r[23]) ? {r[7], 6'h3f, r[13:8]} : r[20:8];
        gp <= r[21];
        osc_in <= r[22];
        xtal <= (r[31:26] == 6'h00) ? ~xtal : xtal;
    end
    // ==========================================
    // Reference model, one step per instruction cycle
    always @(negedge core_clk_i) if (p2 && ext_n) begin
        nx = first ? 13'h0000 : irq ? 13'h0004 : br ? tgt : pc_m + 13'h0001;
        a = nx[11:0];
        er = a < 12'h005 ? 2'h0 : a < 12'h800 ? 2'h1 : a < 12'hfc0 ? 2'h2 : 2'h3;
        chk("pc", 14'(nx), 14'(pc));
        chk("addr", 14'(a), 14'(addr));
        chk("valid", 14'(!(first | irq | br) && pc_m[11:0] < 12'hfc0), 14'(valid));
        if (valid === 1'b1) chk("latch", {~pc_m[1:0], pc_m[11:0]}, latch);
        chk("cal", 14'(a >= 12'hfc0), 14'(cal));
        chk("region", 14'(er), 14'(region));
        if (xtal === xq) begin
            chk("pullup", 14'(!xtal), 14'(opu));
            if (!xtal) chk("gpout", 14'(gp), 14'(oout));
        end
        xq = xtal;
        pc_m = nx;
        first = 1'b0;
    end
    initial begin
        repeat (5) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (3000) @(posedge core_clk_i);
        ext_n <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        first = 1'b1;
        ext_n <= 1'b1;
        repeat (3000) @(posedge core_clk_i);
        test_done;
    end
    initial begin
        #30000;
        failures++;
        test_done;
    end
endmodule // testbench
bind instruction_fetch_pipeline ifp_props props (.core_clk_i, .arst_n_i, .external_reset_n_i,
    .oscillator_in_pin_i,
    .pc_o, .exec_valid_o, .phase_one_o, .phase_two_o, .phase_three_o, .phase_four_o,
    .operand_rd_o, .result_wr_o, .osc_pin_irq_o, .osc_pin_pullup_o, .cal_fetch_o,
    .code_region_o);
`default_nettype wire
